// ---- include/spi_ctl_pkg.sv ----
// Constants, register map and helper function of the SPI control and status unit
// How it works
// - Writing control bit 15 in idle master mode free-runs SCK; bit self-clears.
// - Writing control bit 14 flushes both FIFOs and clears FIFO error; self-clears.
// - Control bit 13 one selects byte-at-a-time mode, zero selects block mode.
// - Control bit 12 selects full duplex; ignored while shared data line is set.
// - Manual master select: control bit 11 one drives select low, zero high.
// - Control bit 10 starts master read or slave receive; master keeps it until start.
// - With control bits 10 and 12 zero a slave transmits instead of receiving.
// - Control bit 9 reads one while the transmit FIFO is not full.
// - Control bit 8 reads one when receive data waits; resets to one.
// - Control bit 7 reads one while the transmit FIFO is empty; resets to one.
// - Control bit 6 reads one while the receive FIFO is full.
// - Transmit length field gives bits sent per byte; zero means eight.
// - Receive length field gives bits captured per byte outside full duplex; zero means eight.
// - Enable bit 2 lets the byte receive flag raise the interrupt.
// - Enable bit 1 lets the byte transmit flag raise the interrupt.
// - Enable bit 0 lets the block transfer flag raise the interrupt.
// - Status bit 7 marks a FIFO underflow or overflow.
// - FIFO error stays set until FIFO initialisation clears it.
// - Status bit 2 reads one once the byte receive condition fired.
// - Status bit 1 reads one once the byte transmit condition fired.
// - Manual select only with select delay field zero; otherwise automatic select.
// - Shared data line bit makes the master send and receive on MOSI, half duplex only; a slave still sends on MISO.
// - Status bit 0 reads one once the block transfer condition fired.
// - Clear register bit 1 clears the byte transmit flag; self-clears.
package spi_ctl_pkg;
  // Register offsets
  localparam logic [15:0] CFG_ADDR  = 16'hc0c8;
  localparam logic [15:0] CTRL_ADDR = 16'hc0ca;
  localparam logic [15:0] IEN_ADDR  = 16'hc0cc;
  localparam logic [15:0] STAT_ADDR = 16'hc0ce;
  localparam logic [15:0] ICLR_ADDR = 16'hc0d0;
  localparam logic [15:0] DATA_ADDR = 16'hc0d6;
  // Control register fields
  localparam int CTL_STROBE = 15;
  localparam int CTL_INIT   = 14;
  localparam int CTL_BYTE   = 13;
  localparam int CTL_FDX    = 12;
  localparam int CTL_SSM    = 11;
  localparam int CTL_RDEN   = 10;
  localparam int CTL_TXLEN  = 3;
  localparam int CTL_RXLEN  = 0;
  // Configuration register fields
  localparam int CFG_SHARED = 15;
  localparam int CFG_PHASE  = 14;
  localparam int CFG_POL    = 13;
  localparam int CFG_SCALE  = 9;
  localparam int CFG_MEN    = 6;
  localparam int CFG_SSEN   = 5;
  localparam int CFG_SSDLY  = 0;
  // Enable, status and clear bits
  localparam int IRQ_RX     = 2;
  localparam int IRQ_TX     = 1;
  localparam int IRQ_BLK    = 0;
  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h801f;
  localparam logic [2:0]  IEN_RESET = 3'h0;
  localparam logic [2:0]  LEN_RESET = 3'h0;
  // FIFO geometry
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW    = 3;
  // SCK timing: divider of the 48 MHz base per scale code
  localparam int CLK_MHZ      = 100;
  localparam int SCK_BASE_MHZ = 48;
  localparam int SCK_DIV [16] = '{4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 128, 192, 128, 192};
  localparam logic [4:0] STROBE_HALVES = 5'h10;
  localparam logic [7:0] FILL_BYTE     = 8'hff;

  // Clock cycles per SCK half period for a scale code
  function automatic logic [7:0] sck_half(input logic [3:0] sel);
    return 8'((SCK_DIV[sel] * CLK_MHZ) / (2 * SCK_BASE_MHZ));
  endfunction
endpackage

// ---- verilog/pin_sync.sv ----
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First flop feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ---- verilog/byte_fifo.sv ----
// Eight-entry byte FIFO with flush
`timescale 1ns/10ps
module byte_fifo
  import spi_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       flush,
  // Fill side
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  output logic            full,
  // Drain side
  input  wire logic       pop,
  output logic      [7:0] pop_data,
  output logic            empty
);
  logic [7:0]       mem_reg [FIFO_DEPTH];
  logic [FIFO_AW:0] wr_reg;
  logic [FIFO_AW:0] rd_reg;
  wire              do_push = push & ~full;
  wire              do_pop  = pop & ~empty;

  // Flags from pointer compare
  assign empty    = (wr_reg == rd_reg);
  assign full     = (wr_reg == {~rd_reg[FIFO_AW], rd_reg[FIFO_AW-1:0]});
  assign pop_data = mem_reg[rd_reg[FIFO_AW-1:0]];

  // Pointers
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_reg + {{FIFO_AW{1'b0}}, do_push};
      rd_reg <= rd_reg + {{FIFO_AW{1'b0}}, do_pop};
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_reg[FIFO_AW-1:0]] <= push_data;
    end
  end
endmodule

// ---- verilog/spi_control_status_unit.sv ----
// SPI control, status and shift engine with register port
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module spi_control_status_unit
  import spi_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rd_data,
  // SPI pins
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        ss_n_in,
  output logic             ss_n_out,
  output logic             ss_n_oe,
  // Interrupt request
  output logic             irq
);
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_XFER = 3'b010, ST_STROBE = 3'b100} eng_state_t;

  eng_state_t  state_reg;
  eng_state_t  state_next;
  logic [15:0] cfg_reg;
  logic        byte_mode_reg;
  logic        fdx_reg;
  logic        ssm_reg;
  logic        rden_reg;
  logic [2:0]  txlen_reg;
  logic [2:0]  rxlen_reg;
  logic [2:0]  ien_reg;
  logic        err_reg;
  logic        rxf_reg;
  logic        txf_reg;
  logic        blkf_reg;
  logic        rx_boot_reg;
  logic [7:0]  div_reg;
  logic [4:0]  hcnt_reg;
  logic [3:0]  bitcnt_reg;
  logic [3:0]  len_reg;
  logic        capt_reg;
  logic        txd_reg;
  logic        rdph_reg;
  logic        slv_busy_reg;
  logic        fill_reg;
  logic [7:0]  tx_sh_reg;
  logic [7:0]  rx_sh_reg;
  logic        out_bit_reg;
  logic        sck_reg;
  logic        sck_d_reg;
  logic [15:0] rd_data_reg;
  logic        sck_oe_reg;
  logic        mosi_oe_reg;
  logic        miso_oe_reg;
  logic        ss_n_reg;
  logic        ss_n_oe_reg;
  logic        irq_reg;
  logic [3:0]  pin_s;
  logic        tx_full;
  logic        tx_empty;
  logic        rx_full;
  logic        rx_empty;
  logic [7:0]  tx_data;
  logic [7:0]  rx_data;

  // Synchronised pins
  pin_sync #(.W(4)) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({sck_in, mosi_in, miso_in, ~ss_n_in}),  // Select enters inverted: reset value means deselected
    .q     (pin_s)
  );
  wire sck_s  = pin_s[3];
  wire mosi_s = pin_s[2];
  wire miso_s = pin_s[1];
  wire ss_act = pin_s[0];

  // Register decode
  wire cfg_wr   = wr_stb & (addr == CFG_ADDR);
  wire ctrl_wr  = wr_stb & (addr == CTRL_ADDR);
  wire ien_wr   = wr_stb & (addr == IEN_ADDR);
  wire iclr_wr  = wr_stb & (addr == ICLR_ADDR);
  wire data_wr  = wr_stb & (addr == DATA_ADDR);
  wire data_rd  = rd_stb & (addr == DATA_ADDR);
  wire init_wr  = ctrl_wr & wr_data[CTL_INIT];
  wire master   = cfg_reg[CFG_MEN];
  wire shared   = cfg_reg[CFG_SHARED];
  wire phase    = cfg_reg[CFG_PHASE];
  wire pol      = cfg_reg[CFG_POL];
  wire m_idle   = (state_reg == ST_IDLE);
  wire auto_ss  = (cfg_reg[CFG_SSDLY +: 5] != 5'h00);

  // Engine start decisions
  wire strobe_go = ctrl_wr & wr_data[CTL_STROBE] & master & m_idle;
  wire m_rd_go   = master & m_idle & rden_reg & ~strobe_go;
  wire m_wr_go   = master & m_idle & ~rden_reg & ~tx_empty & ~strobe_go;
  wire s_tx      = ~rden_reg | fdx_reg;
  wire s_rx      = rden_reg | fdx_reg;
  wire s_go      = ~master & ss_act & ~slv_busy_reg;
  wire load_ev   = m_rd_go | m_wr_go | s_go;
  wire tx_pop    = m_wr_go | (s_go & s_tx & ~tx_empty);
  wire [7:0] load_byte = (m_rd_go | tx_empty) ? FILL_BYTE : tx_data;
  wire [2:0] len_sel   = (m_rd_go | (~master & s_rx & ~fdx_reg)) ? rxlen_reg : txlen_reg;
  wire [3:0] len_bits  = {(len_sel == 3'h0), len_sel};

  // Edge events of both roles
  wire tick      = ~m_idle & (div_reg == 8'h00);
  wire lead      = ~hcnt_reg[0];
  wire in_xfer   = (state_reg == ST_XFER);
  wire s_lead    = slv_busy_reg & (sck_s != sck_d_reg) & (sck_s == pol);
  wire s_trail   = slv_busy_reg & (sck_s != sck_d_reg) & (sck_s != pol);
  wire underflow = s_lead & txd_reg & fill_reg & (bitcnt_reg == 4'h0);
  wire shift_ev  = master ? (tick & in_xfer & (lead == phase)) : s_trail;
  wire samp_ev   = master ? (tick & in_xfer & (lead != phase)) : s_lead;
  wire done_ev   = samp_ev & ((bitcnt_reg + 4'h1) == len_reg);
  wire last_half = (hcnt_reg == ({len_reg, 1'b0} - 5'h01));
  wire in_bit    = (master & ~shared) ? miso_s : mosi_s;
  wire rx_push   = done_ev & capt_reg;
  wire rd_phase  = m_rd_go | (rdph_reg & in_xfer);

  // Master state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (strobe_go) begin
          state_next = ST_STROBE;
        end else if (m_rd_go | m_wr_go) begin
          state_next = ST_XFER;
        end
      end
      ST_XFER: begin
        if (~master | (tick & last_half)) begin
          state_next = ST_IDLE;
        end
      end
      ST_STROBE: begin
        if (tick & (hcnt_reg == STROBE_HALVES - 5'h01)) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Transmit and receive FIFOs
  byte_fifo u_tx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (init_wr),
    .push      (data_wr),
    .push_data (wr_data[7:0]),
    .full      (tx_full),
    .pop       (tx_pop),
    .pop_data  (tx_data),
    .empty     (tx_empty)
  );
  byte_fifo u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (init_wr),
    .push      (rx_push),
    .push_data ({rx_sh_reg[6:0], in_bit}),  // Last bit joins at the capture edge
    .full      (rx_full),
    .pop       (data_rd),
    .pop_data  (rx_data),
    .empty     (rx_empty)
  );

  // Software registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg       <= CFG_RESET;
      byte_mode_reg <= 1'b0;
      fdx_reg       <= 1'b0;
      ssm_reg       <= 1'b0;
      rden_reg      <= 1'b0;
      txlen_reg     <= LEN_RESET;
      rxlen_reg     <= LEN_RESET;
      ien_reg       <= IEN_RESET;
    end else begin
      if (cfg_wr) begin
        cfg_reg <= {wr_data[15:8], 1'b0, m_idle ? wr_data[CFG_MEN] : master, wr_data[5:0]};
      end
      if (ctrl_wr) begin
        byte_mode_reg <= wr_data[CTL_BYTE];
        fdx_reg       <= wr_data[CTL_FDX] & ~shared;
        ssm_reg       <= wr_data[CTL_SSM];
        rden_reg      <= wr_data[CTL_RDEN];
        txlen_reg     <= wr_data[CTL_TXLEN +: 3];
        rxlen_reg     <= wr_data[CTL_RXLEN +: 3];
      end else if (m_rd_go) begin
        rden_reg <= 1'b0;
      end
      if (ien_wr) begin
        ien_reg <= wr_data[2:0];
      end
    end
  end

  // Sticky flags; events win over software clears, FIFO init clears the error
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_reg     <= 1'b0;
      rxf_reg     <= 1'b0;
      txf_reg     <= 1'b0;
      blkf_reg    <= 1'b0;
      rx_boot_reg <= 1'b1;
    end else begin
      err_reg     <= ~init_wr & (err_reg | underflow | (rx_push & rx_full) | (data_wr & tx_full));
      rxf_reg     <= (rx_push & byte_mode_reg) | (rxf_reg & ~data_rd);
      txf_reg     <= (done_ev & txd_reg & byte_mode_reg) | (txf_reg & ~(iclr_wr & wr_data[IRQ_TX]));
      blkf_reg    <= (done_ev & ~byte_mode_reg) | (blkf_reg & ~(iclr_wr & wr_data[IRQ_BLK]));
      rx_boot_reg <= rx_boot_reg & ~init_wr & ~data_rd;
    end
  end

  // Shift engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      div_reg      <= 8'h00;
      hcnt_reg     <= 5'h00;
      sck_reg      <= 1'b1;
      sck_d_reg    <= 1'b0;
      bitcnt_reg   <= 4'h0;
      len_reg      <= 4'h8;
      capt_reg     <= 1'b0;
      txd_reg      <= 1'b0;
      rdph_reg     <= 1'b0;
      slv_busy_reg <= 1'b0;
      fill_reg     <= 1'b0;
      tx_sh_reg    <= 8'h00;
      rx_sh_reg    <= 8'h00;
      out_bit_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sck_d_reg    <= sck_s;
      div_reg      <= (m_idle | tick) ? sck_half(cfg_reg[CFG_SCALE +: 4]) - 8'h01 : div_reg - 8'h01;
      hcnt_reg     <= m_idle ? 5'h00 : hcnt_reg + {4'h0, tick};
      sck_reg      <= (m_idle | (state_next == ST_IDLE)) ? ~pol : sck_reg ^ tick;
      slv_busy_reg <= ~master & ss_act & (s_go | (slv_busy_reg & ~done_ev));
      if (load_ev) begin
        bitcnt_reg <= 4'h0;
        len_reg    <= len_bits;
        capt_reg   <= master ? (m_rd_go | fdx_reg) : s_rx;
        txd_reg    <= m_wr_go | (s_go & s_tx);
        rdph_reg   <= m_rd_go;
        fill_reg   <= tx_empty;  // Fill byte only counts as underflow once clocked
        rx_sh_reg  <= 8'h00;
        if (~master | ~phase) begin
          out_bit_reg <= load_byte[7];
          tx_sh_reg   <= {load_byte[6:0], 1'b0};
        end else begin
          tx_sh_reg <= load_byte;
        end
      end else begin
        if (samp_ev) begin
          bitcnt_reg <= bitcnt_reg + 4'h1;
          rx_sh_reg  <= {rx_sh_reg[6:0], in_bit};
        end
        if (shift_ev) begin
          out_bit_reg <= tx_sh_reg[7];
          tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Read data mux
  wire [15:0] ctrl_rd = {2'b00, byte_mode_reg, fdx_reg, ssm_reg, rden_reg, ~tx_full,
                         ~rx_empty | rx_boot_reg, tx_empty, rx_full, txlen_reg, rxlen_reg};
  wire [15:0] cfg_rd  = {cfg_reg[15:8], ~m_idle, cfg_reg[6:0]};
  wire [15:0] stat_rd = {8'h00, err_reg, 4'h0, rxf_reg, txf_reg, blkf_reg};
  wire [15:0] rd_mux  = (addr == CFG_ADDR)  ? cfg_rd :
                        (addr == CTRL_ADDR) ? ctrl_rd :
                        (addr == IEN_ADDR)  ? {13'h0000, ien_reg} :
                        (addr == STAT_ADDR) ? stat_rd :
                        (addr == DATA_ADDR) ? {8'h00, rx_data} : 16'h0000;
  wire [2:0]  flags   = {rxf_reg, txf_reg, blkf_reg};

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_reg <= 16'h0000;
      sck_oe_reg  <= 1'b0;
      mosi_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      ss_n_reg    <= 1'b1;
      ss_n_oe_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      rd_data_reg <= rd_stb ? rd_mux : 16'h0000;
      sck_oe_reg  <= master;
      mosi_oe_reg <= master & ~(shared & rd_phase);
      miso_oe_reg <= ~master & ss_act & s_tx;
      ss_n_reg    <= auto_ss ? (state_next != ST_XFER) : ~ssm_reg;
      ss_n_oe_reg <= master & cfg_reg[CFG_SSEN];
      irq_reg     <= |(flags & ien_reg);
    end
  end

  assign rd_data  = rd_data_reg;
  assign sck_out  = sck_reg;
  assign sck_oe   = sck_oe_reg;
  assign mosi_out = out_bit_reg;
  assign mosi_oe  = mosi_oe_reg;
  assign miso_out = out_bit_reg;
  assign miso_oe  = miso_oe_reg;
  assign ss_n_out = ss_n_reg;
  assign ss_n_oe  = ss_n_oe_reg;
  assign irq      = irq_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_strobe_req;
    strobe_go;
  endsequence
  sequence s_strobe_run;
    (state_reg == ST_STROBE) ##1 (state_reg == ST_STROBE);
  endsequence
  property p_strobe_start;
    s_strobe_req |=> s_strobe_run;
  endproperty
  a_strobe_start: assert property (p_strobe_start) else $error("strobe did not start");
  property p_strobe_self_clear;
    rd_stb & (addr == CTRL_ADDR) |=> ~rd_data_reg[CTL_STROBE] & ~rd_data_reg[CTL_INIT];
  endproperty
  a_strobe_self_clear: assert property (p_strobe_self_clear) else $error("self-clearing bit read one");
  property p_init_flush;
    init_wr |=> tx_empty & rx_empty & ~err_reg;
  endproperty
  a_init_flush: assert property (p_init_flush) else $error("init did not flush");
  property p_fdx_blocked;
    ctrl_wr & shared |=> ~fdx_reg;
  endproperty
  a_fdx_blocked: assert property (p_fdx_blocked) else $error("full duplex set with shared line");
  property p_ss_manual;
    master & ~auto_ss |=> ss_n_out == ~$past(ssm_reg);
  endproperty
  a_ss_manual: assert property (p_ss_manual) else $error("manual select level wrong");
  sequence s_rd_start;
    m_rd_go & ~ctrl_wr;
  endsequence
  property p_read_start;
    s_rd_start |=> in_xfer & ~rden_reg ##1 in_xfer;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read phase did not start");
  property p_rden_sticky;
    rden_reg & ~m_rd_go & ~ctrl_wr |=> rden_reg;
  endproperty
  a_rden_sticky: assert property (p_rden_sticky) else $error("read enable dropped early");
  property p_tx_status;
    rd_stb & (addr == CTRL_ADDR) |=> (rd_data_reg[9] == ~$past(tx_full)) && (rd_data_reg[7] == $past(tx_empty));
  endproperty
  a_tx_status: assert property (p_tx_status) else $error("transmit status bits wrong");
  property p_err_hold;
    err_reg & ~init_wr |=> err_reg;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("fifo error lost");
  property p_irq_gate;
    (|(flags & ien_reg)) |=> irq ##1 $past(|(flags & ien_reg)) == irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt request wrong");
endmodule

// ---- test/spi_slave_model.sv ----
// Behavioural SPI slave that answers the unit while it is bus master
`timescale 1ns/10ps
module spi_slave_model #(
  parameter logic POL = 1'b0
) (
  // Link pins
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso,
  // Bench side
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output int              nbits,
  output int              frames
);
  logic [7:0] sh;

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    nbits = 0;
    frames = 0;
  end
  // Selection loads the answer MSB first
  always @(negedge ss_n) begin
    sh = tx_byte;
    miso = sh[7];
    nbits = 0;
    rx_byte = 8'h00;
  end
  // Released line shows the inverse of its last level
  always @(posedge ss_n) begin
    frames++;
    miso = ~miso;
  end
  // Leading edge samples, trailing edge shifts the next bit
  always @(sck) begin
    if (!ss_n) begin
      if (sck == POL) begin
        rx_byte = {rx_byte[6:0], mosi};
        nbits++;
      end else begin
        sh = {sh[6:0], 1'b0};
        miso = sh[7];
      end
    end
  end
endmodule

// ---- test/spi_control_status_unit_tb_top.sv ----
// Self-checking bench of the SPI control and status unit
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module spi_control_status_unit_tb_top;
  import spi_ctl_pkg::*;
  typedef struct {logic [15:0] a, d, m, e;} row_t;
  logic        clk, rst_n, wr_stb, rd_stb, sck_drv, mosi_drv, ss_drv;
  logic [15:0] addr, wr_data, rd_data, v;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe, irq, p_miso;
  logic [7:0]  p_tx, p_rx, s_rx;
  int          p_bits, p_frames, bad_count, tests_run, t, i;
  logic        s;
  row_t        rows [9] = '{
    '{CTRL_ADDR, 16'h2000, 16'h3c3f, 16'h2000}, '{CTRL_ADDR, 16'h0000, 16'h3c3f, 16'h0000},
    '{CTRL_ADDR, 16'h0028, 16'h3c3f, 16'h0028}, '{CTRL_ADDR, 16'h0007, 16'h3c3f, 16'h0007},
    '{CTRL_ADDR, 16'h1000, 16'h3c3f, 16'h0000}, '{IEN_ADDR, 16'h0004, 16'hffff, 16'h0004},
    '{IEN_ADDR, 16'h0002, 16'hffff, 16'h0002}, '{IEN_ADDR, 16'h0001, 16'hffff, 16'h0001},
    '{STAT_ADDR, 16'h0087, 16'hffff, 16'h0000}};
  // Pin levels from every driver's enable
  wire sck_w  = sck_oe ? sck_out : sck_drv;
  wire mosi_w = mosi_oe ? mosi_out : mosi_drv;
  wire ss_w   = ss_n_oe ? ss_n_out : ss_drv;
  wire miso_w = miso_oe ? miso_out : p_miso;

  spi_control_status_unit uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
    .ss_n_in(ss_w), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .irq(irq));
  spi_slave_model peer (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(p_miso), .tx_byte(p_tx),
    .rx_byte(p_rx), .nbits(p_bits), .frames(p_frames));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Register port bus cycles
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rd_data;
    `CHK(nm, e, v & m)
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded wait for the peer to be released after a frame
  task automatic wait_frame;
    int n;
    int k;
    n = p_frames;
    for (k = 0; k < 3000 && p_frames == n; k++) @(posedge clk);
    if (p_frames == n) begin
      bad_count++;
      $display("BAD frame_wait expected done seen timeout");
      results;
    end else begin
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  // External master sends one byte, 80 ns link period
  task automatic slave_byte(input logic [7:0] b);
    int k;
    ss_drv <= 1'b0;
    repeat (8) @(posedge clk);
    for (k = 7; k >= 0; k--) begin
      mosi_drv <= b[k];
      repeat (4) @(posedge clk);
      s_rx = {s_rx[6:0], miso_w};
      sck_drv <= 1'b0;
      repeat (4) @(posedge clk);
      sck_drv <= 1'b1;
    end
    repeat (8) @(posedge clk);
    ss_drv <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    addr = 16'h0000;
    wr_data = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    sck_drv = 1'b1;
    mosi_drv = 1'b0;
    ss_drv = 1'b1;
    p_tx = 8'h3c;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk("ctrl_reset", CTRL_ADDR, 16'hffff, 16'h0380);
    chk("ien_reset", IEN_ADDR, 16'hffff, 16'h0000);
    chk("stat_reset", STAT_ADDR, 16'hffff, 16'h0000);
    chk("unmapped", 16'hc0e0, 16'hffff, 16'h0000);
    for (i = 0; i < 9; i++) begin
      wr(rows[i].a, rows[i].d);
      chk("row", rows[i].a, rows[i].m, rows[i].e);
    end
    // Slave idle: fill the transmit FIFO past its depth
    wr(CTRL_ADDR, 16'h2000);
    for (i = 0; i < FIFO_DEPTH; i++) wr(DATA_ADDR, 16'(i));
    chk("tx_full", CTRL_ADDR, 16'h0280, 16'h0000);
    wr(DATA_ADDR, 16'h0055);
    chk("fifo_err", STAT_ADDR, 16'h0080, 16'h0080);
    chk("fifo_err_held", STAT_ADDR, 16'h0080, 16'h0080);
    wr(CTRL_ADDR, 16'h6000);
    chk("init_err", STAT_ADDR, 16'h0080, 16'h0000);
    chk("init_fifo", CTRL_ADDR, 16'hc280, 16'h0280);
    // Slave receive of one byte
    wr(CTRL_ADDR, 16'h2400);
    wr(IEN_ADDR, 16'h0004);
    slave_byte(8'h96);
    chk("rx_ready", CTRL_ADDR, 16'h0100, 16'h0100);
    chk("rx_flag", STAT_ADDR, 16'h0004, 16'h0004);
    `CHK("irq_rx", 1'b1, irq)
    chk("rx_data", DATA_ADDR, 16'h00ff, 16'h0096);
    // Slave transmit of one byte, taken on the leading edges
    wr(CTRL_ADDR, 16'h2000);
    wr(DATA_ADDR, 16'h005a);
    slave_byte(8'h00);
    `CHK("slv_tx", 8'h5a, s_rx)
    chk("slv_no_err", STAT_ADDR, 16'h0080, 16'h0000);
    // Master, manual then automatic select
    wr(CFG_ADDR, 16'h0060);
    wr(CTRL_ADDR, 16'h1000);
    chk("fdx", CTRL_ADDR, 16'h1000, 16'h1000);
    `CHK("oe_master", 3'b111, {sck_oe, mosi_oe, ss_n_oe})
    wr(CTRL_ADDR, 16'h2800);
    repeat (2) @(posedge clk);
    #1 `CHK("ss_manual_on", 1'b0, ss_n_out)
    wr(CTRL_ADDR, 16'h2000);
    repeat (2) @(posedge clk);
    #1 `CHK("ss_manual_off", 1'b1, ss_n_out)
    wr(CFG_ADDR, 16'h0061);
    wr(CTRL_ADDR, 16'h2800);
    repeat (2) @(posedge clk);
    #1 `CHK("ss_auto", 1'b1, ss_n_out)
    wr(CTRL_ADDR, 16'h2000);
    // Free-running strobe edges
    wr(CTRL_ADDR, 16'ha000);
    t = 0;
    s = sck_out;
    repeat (400) begin
      @(posedge clk);
      #1 if (sck_out !== s) begin
        t++;
        s = sck_out;
      end
    end
    `CHK("strobe_edges", 16, t)
    chk("strobe_clr", CTRL_ADDR, 16'h8000, 16'h0000);
    // Byte transmit, full and partial
    wr(IEN_ADDR, 16'h0002);
    wr(DATA_ADDR, 16'h00a5);
    wait_frame;
    `CHK("tx_byte", 8'ha5, p_rx)
    `CHK("tx_bits", 8, p_bits)
    chk("tx_flag", STAT_ADDR, 16'h0002, 16'h0002);
    `CHK("irq_tx", 1'b1, irq)
    wr(ICLR_ADDR, 16'h0002);
    chk("tx_clr", STAT_ADDR, 16'h0002, 16'h0000);
    `CHK("irq_clr", 1'b0, irq)
    wr(CTRL_ADDR, 16'h2018);
    wr(DATA_ADDR, 16'h00a0);
    wait_frame;
    `CHK("tx_part", 8'h05, p_rx)
    `CHK("tx_part_bits", 3, p_bits)
    // Master read phase, full and partial
    wr(CTRL_ADDR, 16'h2400);
    wait_frame;
    chk("rden_clr", CTRL_ADDR, 16'h0400, 16'h0000);
    chk("rd_data", DATA_ADDR, 16'h00ff, 16'h003c);
    wr(CTRL_ADDR, 16'h2404);
    wait_frame;
    chk("rd_part", DATA_ADDR, 16'h00ff, 16'h0003);
    // Block mode completion
    wr(CTRL_ADDR, 16'h0000);
    wr(IEN_ADDR, 16'h0001);
    wr(DATA_ADDR, 16'h0011);
    wait_frame;
    chk("blk_flag", STAT_ADDR, 16'h0003, 16'h0003);
    `CHK("irq_blk", 1'b1, irq)
    results;
  end
endmodule
